/* File: inc/ebw_pkg.sv */
`default_nettype none
package ebw_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_TIMING = 8'h00;
  localparam logic [7:0] OFS_ADDR   = 8'h04;
  localparam logic [7:0] OFS_WDATA  = 8'h08;
  localparam logic [7:0] OFS_CTRL   = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_RDATA  = 8'h14;

  // zone_timing_config field positions
  localparam int RD_LEAD_LSB   = 0;
  localparam int RD_ACT_LSB    = 2;
  localparam int RD_TRAIL_LSB  = 5;
  localparam int READY_EN_BIT  = 7;
  localparam int DOUBLING_BIT  = 8;
  localparam int WR_LEAD_LSB   = 9;
  localparam int WR_ACT_LSB    = 11;
  localparam int WR_TRAIL_LSB  = 14;
  localparam int STYLE_BIT     = 16;
  localparam int TIMING_W      = 17;

  // Control and status bits
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_WRITE_BIT = 1;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_DONE_BIT  = 1;

  localparam logic [TIMING_W-1:0] TIMING_RST = 17'h0c9ff;
  localparam logic [18:0]         ADDR_RST   = 19'h00000;

  localparam int ADDR_W = 19;
  localparam int DATA_W = 16;
  localparam int CNT_W  = 8;

  // Async ready samples this many timing clocks early
  localparam logic [7:0] ASYNC_EARLY = 8'h02;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_ALIGN  = 3'b001,
    ST_LEAD   = 3'b010,
    ST_ACTIVE = 3'b011,
    ST_TRAIL  = 3'b100
  } ebw_state_t;
endpackage : ebw_pkg
`default_nettype wire

/* File: core/ebw_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Each access begins its lead period on a rising bus clock edge.
// - Alignment cycles hold every strobe and control line inactive.
// - Idle and alignment cycles keep the last address on the bus.
// - Async read: first ready sample two cycles before lead plus active end.
// - Sync write: first ready sample after write lead plus active cycles.
// - Async write: first ready sample two cycles before lead plus active end.
// - Ready high at a sample completes; far side holds ready low to stretch.
// - Ready low is resampled every cycle, holding the lead or active period until high.
// - Style 1 selects async sampling, 0 sync; ready enable must be 1.
// - Sync read: first ready sample after read lead plus active cycles.
module ebw_ctrl (
  // AHB-Lite slave
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // External bus pins
  output logic             bus_clock_output,
  output logic [18:0]      ext_addr,
  output logic [15:0]      ext_data_out,
  output logic             ext_data_oe,
  input  wire logic [15:0] ext_data_in,
  output logic             chip_select_n,
  output logic             read_strobe_n,
  output logic             write_strobe_n,
  output logic             read_not_write_line,
  input  wire logic        external_ready_in
);

  function automatic logic [7:0] span(input logic [2:0] v, input logic dbl);
    span = dbl ? {4'h0, v, 1'b0} : {5'h00, v};
  endfunction : span

  // ---------------- Register bus ----------------
  logic [ebw_pkg::TIMING_W-1:0] timing_q, timing_d;
  logic [18:0] addr_reg_q, addr_reg_d;
  logic [15:0] wdata_q, wdata_d;
  logic [15:0] rdata_q, rdata_d;
  logic        wr_cmd_q, wr_cmd_d;
  logic        pend_q, pend_d;
  logic        done_q, done_d;
  logic        dph_wr_q, dph_wr_d;
  logic [7:0]  dph_ofs_q, dph_ofs_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic        finish;
  logic        busy;
  logic        start_acc;
  logic        aphase;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;
  assign aphase    = hsel && hready && htrans[1];

  always_comb begin
    timing_d   = timing_q;
    addr_reg_d = addr_reg_q;
    wdata_d    = wdata_q;
    wr_cmd_d   = wr_cmd_q;
    pend_d     = pend_q;
    done_d     = done_q;
    rdata_d    = rdata_q;
    hrdata_d   = hrdata_q;
    dph_wr_d   = aphase && hwrite;
    dph_ofs_d  = aphase ? haddr[7:0] : dph_ofs_q;
    if (dph_wr_q) begin
      unique case (dph_ofs_q)
        ebw_pkg::OFS_TIMING: timing_d   = hwdata[ebw_pkg::TIMING_W-1:0];
        ebw_pkg::OFS_ADDR:   addr_reg_d = hwdata[18:0];
        ebw_pkg::OFS_WDATA:  wdata_d    = hwdata[15:0];
        ebw_pkg::OFS_CTRL: begin
          if (hwdata[ebw_pkg::CTRL_START_BIT] && !pend_q && !busy) begin
            pend_d   = 1'b1;
            wr_cmd_d = hwdata[ebw_pkg::CTRL_WRITE_BIT];
            done_d   = 1'b0;
          end
        end
        default: ;
      endcase
    end
    if (start_acc)
      pend_d = 1'b0;
    if (finish) begin
      done_d = 1'b1;
      if (!wr_cmd_q)
        rdata_d = ext_data_in;
    end
    if (aphase && !hwrite) begin
      unique case (haddr[7:0])
        ebw_pkg::OFS_TIMING: hrdata_d = {15'h0000, timing_q};
        ebw_pkg::OFS_ADDR:   hrdata_d = {13'h0000, addr_reg_q};
        ebw_pkg::OFS_WDATA:  hrdata_d = {16'h0000, wdata_q};
        ebw_pkg::OFS_CTRL:   hrdata_d = {30'h00000000, wr_cmd_q, pend_q};
        ebw_pkg::OFS_STATUS: hrdata_d = {30'h00000000, done_q,
                                         busy || pend_q};
        ebw_pkg::OFS_RDATA:  hrdata_d = {16'h0000, rdata_q};
        default:             hrdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timing_q   <= ebw_pkg::TIMING_RST;
      addr_reg_q <= ebw_pkg::ADDR_RST;
      wdata_q    <= 16'h0000;
      rdata_q    <= 16'h0000;
      wr_cmd_q   <= 1'b0;
      pend_q     <= 1'b0;
      done_q     <= 1'b0;
      dph_wr_q   <= 1'b0;
      dph_ofs_q  <= 8'h00;
      hrdata_q   <= 32'h00000000;
    end else begin
      timing_q   <= timing_d;
      addr_reg_q <= addr_reg_d;
      wdata_q    <= wdata_d;
      rdata_q    <= rdata_d;
      wr_cmd_q   <= wr_cmd_d;
      pend_q     <= pend_d;
      done_q     <= done_d;
      dph_wr_q   <= dph_wr_d;
      dph_ofs_q  <= dph_ofs_d;
      hrdata_q   <= hrdata_d;
    end
  end

  // ---------------- Timing fields ----------------
  logic       rdy_en, style, dbl;
  logic [7:0] len_lead, len_act, len_trail, first_smp, la_sum;

  assign rdy_en = timing_q[ebw_pkg::READY_EN_BIT];
  assign style  = timing_q[ebw_pkg::STYLE_BIT];
  assign dbl    = timing_q[ebw_pkg::DOUBLING_BIT];

  always_comb begin
    if (wr_cmd_q) begin
      len_lead  = span({1'b0, timing_q[ebw_pkg::WR_LEAD_LSB +: 2]}, dbl);
      len_act   = span(timing_q[ebw_pkg::WR_ACT_LSB +: 3], dbl);
      len_trail = span({1'b0, timing_q[ebw_pkg::WR_TRAIL_LSB +: 2]}, dbl);
    end else begin
      len_lead  = span({1'b0, timing_q[ebw_pkg::RD_LEAD_LSB +: 2]}, dbl);
      len_act   = span(timing_q[ebw_pkg::RD_ACT_LSB +: 3], dbl);
      len_trail = span({1'b0, timing_q[ebw_pkg::RD_TRAIL_LSB +: 2]}, dbl);
    end
    if (len_lead == 8'h00)
      len_lead = 8'h01;
    la_sum = len_lead + len_act;
    // Async samples earlier to cover the extra synchroniser delay
    if (style && la_sum > ebw_pkg::ASYNC_EARLY)
      first_smp = la_sum - ebw_pkg::ASYNC_EARLY;
    else if (style)
      first_smp = 8'h01;
    else
      first_smp = la_sum;
  end

  // ---------------- Ready input synchroniser ----------------
  logic rs1_q, rs2_q, rs3_q, rdy_q, rdy_d;
  always_comb begin
    rdy_d = (rs2_q == rs3_q) ? rs3_q : rdy_q;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rs1_q <= 1'b0;
      rs2_q <= 1'b0;
      rs3_q <= 1'b0;
      rdy_q <= 1'b0;
    end else begin
      rs1_q <= external_ready_in;
      rs2_q <= rs1_q;
      rs3_q <= rs2_q;
      rdy_q <= rdy_d;
    end
  end

  // ---------------- Bus clock divider and access FSM ----------------
  ebw_pkg::ebw_state_t st_q, st_d;
  logic [1:0]  div_q, div_d;
  logic        bco_q, bco_d;
  logic [7:0]  el_q, el_d, trl_q, trl_d;
  logic        acc_q, acc_d;
  logic [18:0] ea_q, ea_d;
  logic        rise;
  logic        smp_win, smp_win_q;
  logic        stall;
  logic [7:0]  el_nx;

  assign busy    = (st_q != ebw_pkg::ST_IDLE);
  assign el_nx   = el_q + 8'h01;
  assign smp_win = rdy_en && !acc_q && (el_nx >= first_smp) &&
                   (st_q == ebw_pkg::ST_LEAD || st_q == ebw_pkg::ST_ACTIVE);
  assign stall   = smp_win && !rdy_q;

  always_comb begin
    div_d     = div_q + 2'h1;
    bco_d     = dbl ? div_d[1] : div_d[0];
    rise      = bco_d && !bco_q;
    st_d      = st_q;
    el_d      = el_q;
    acc_d     = acc_q || (smp_win && rdy_q);
    ea_d      = ea_q;
    start_acc = 1'b0;
    finish    = 1'b0;
    trl_d     = (st_q == ebw_pkg::ST_TRAIL) ? trl_q + 8'h01 : 8'h00;
    unique case (st_q)
      ebw_pkg::ST_IDLE, ebw_pkg::ST_ALIGN: begin
        if (pend_q && rise) begin
          st_d      = ebw_pkg::ST_LEAD;
          start_acc = 1'b1;
          el_d      = 8'h00;
          acc_d     = 1'b0;
          ea_d      = addr_reg_q;
        end else if (pend_q) begin
          st_d = ebw_pkg::ST_ALIGN;
        end
      end
      ebw_pkg::ST_LEAD, ebw_pkg::ST_ACTIVE: begin
        if (!stall) begin
          el_d = el_nx;
          if (el_nx == la_sum)
            st_d = (len_trail == 8'h00) ? ebw_pkg::ST_IDLE
                                        : ebw_pkg::ST_TRAIL;
          else if (el_nx >= len_lead)
            st_d = ebw_pkg::ST_ACTIVE;
          if (el_nx == la_sum && len_trail == 8'h00)
            finish = 1'b1;
        end
      end
      ebw_pkg::ST_TRAIL: begin
        el_d = el_nx;
        if (el_nx == la_sum + len_trail) begin
          st_d   = ebw_pkg::ST_IDLE;
          finish = 1'b1;
        end
      end
      default: st_d = ebw_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q  <= ebw_pkg::ST_IDLE;
      div_q <= 2'h0;
      bco_q <= 1'b0;
      el_q  <= 8'h00;
      acc_q <= 1'b0;
      ea_q  <= ebw_pkg::ADDR_RST;
      trl_q <= 8'h00;
      smp_win_q <= 1'b0;
    end else begin
      st_q  <= st_d;
      div_q <= div_d;
      bco_q <= bco_d;
      el_q  <= el_d;
      acc_q <= acc_d;
      ea_q  <= ea_d;
      trl_q <= trl_d;
      smp_win_q <= smp_win;
    end
  end

  // Strobes only inside an access; address register only loads at start
  assign bus_clock_output    = bco_q;
  assign ext_addr            = ea_q;
  assign ext_data_out        = wdata_q;
  assign chip_select_n       = !(busy && st_q != ebw_pkg::ST_ALIGN);
  assign read_strobe_n       = !(st_q == ebw_pkg::ST_ACTIVE && !wr_cmd_q);
  assign write_strobe_n      = !(st_q == ebw_pkg::ST_ACTIVE && wr_cmd_q);
  assign read_not_write_line = !(!chip_select_n && wr_cmd_q);
  assign ext_data_oe         = !chip_select_n && wr_cmd_q;

  // ---------------- Assertions ----------------
  logic in_acc, first_win;
  assign in_acc    = !chip_select_n;
  assign first_win = smp_win && !smp_win_q;

  a_lead_on_rise: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_q == ebw_pkg::ST_LEAD && $past(st_q) != ebw_pkg::ST_LEAD) |->
    (bco_q && !$past(bco_q)))
    else $error("access began off a bus clock rise");
  a_align_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_q == ebw_pkg::ST_ALIGN || st_q == ebw_pkg::ST_IDLE) |->
    (chip_select_n && read_strobe_n && write_strobe_n &&
     read_not_write_line && !ext_data_oe))
    else $error("strobe active outside an access");
  a_addr_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    !(st_q == ebw_pkg::ST_LEAD && $past(st_q) != ebw_pkg::ST_LEAD) |->
    $stable(ext_addr))
    else $error("address moved outside access start");
  a_async_rd_first: assert property (@(posedge hclk) disable iff (!hresetn)
    (first_win && style && !wr_cmd_q && la_sum > 8'h02) |->
    (el_nx == la_sum - 8'h02))
    else $error("async read first sample misplaced");
  a_sync_wr_first: assert property (@(posedge hclk) disable iff (!hresetn)
    (first_win && !style && wr_cmd_q) |-> (el_nx == la_sum))
    else $error("sync write first sample misplaced");
  a_async_wr_first: assert property (@(posedge hclk) disable iff (!hresetn)
    (first_win && style && wr_cmd_q && la_sum > 8'h02) |->
    (el_nx == la_sum - 8'h02))
    else $error("async write first sample misplaced");
  a_ready_accept: assert property (@(posedge hclk) disable iff (!hresetn)
    (smp_win && rdy_q) |=> (acc_q && st_q != ebw_pkg::ST_ALIGN))
    else $error("ready high not accepted");
  a_ready_resample: assert property (@(posedge hclk) disable iff (!hresetn)
    stall |=> ($stable(el_q) && in_acc && !acc_q))
    else $error("ready low did not extend the access");
  a_sync_rd_first: assert property (@(posedge hclk) disable iff (!hresetn)
    (first_win && !style && !wr_cmd_q) |-> (el_nx == la_sum))
    else $error("sync read first sample misplaced");
  a_ready_ignored: assert property (@(posedge hclk) disable iff (!hresetn)
    (!rdy_en && in_acc) |-> !stall)
    else $error("ready honoured while disabled");
  a_trail_full: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_q == ebw_pkg::ST_TRAIL ##1 !in_acc) |-> (trl_q == len_trail))
    else $error("trail period cut short");

  c_read_sync:  cover property (@(posedge hclk) disable iff (!hresetn)
    stall && !style && !wr_cmd_q ##1 !stall ##[1:40] finish);
  c_write_async: cover property (@(posedge hclk) disable iff (!hresetn)
    stall && style && wr_cmd_q ##[1:40] finish);
  c_align:      cover property (@(posedge hclk) disable iff (!hresetn)
    st_q == ebw_pkg::ST_ALIGN ##1 st_q == ebw_pkg::ST_LEAD);
  c_no_ready:   cover property (@(posedge hclk) disable iff (!hresetn)
    !rdy_en && finish);
endmodule : ebw_ctrl
`default_nettype wire

/* File: verification/ebw_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ebw_mem_model (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Bus pins
  input  wire logic        chip_select_n,
  input  wire logic        write_strobe_n,
  input  wire logic        read_not_write_line,
  input  wire logic [15:0] ext_data_out,
  input  wire logic        ext_data_oe,
  output logic [15:0]      ext_data_in,
  output logic             external_ready_in,
  // Cycles of stretch after select falls
  input  wire logic [7:0]  hold_low
);
  logic [7:0]  cnt_q;
  logic [15:0] mem_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 8'h00;
      mem_q <= 16'h0000;
    end else begin
      cnt_q <= chip_select_n ? 8'h00 : cnt_q + 8'h01;
      if (!write_strobe_n && ext_data_oe) begin
        mem_q <= ext_data_out;
      end
    end
  end

  // Ready is low while deselected and rises once select has been low hold_low cycles
  assign external_ready_in = !chip_select_n && (cnt_q >= hold_low);
  // Data is only valid while a read holds select
  assign ext_data_in = (!chip_select_n && read_not_write_line) ? mem_q
                                                               : ~mem_q;
endmodule : ebw_mem_model
`default_nettype wire

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [1:0]  htrans;
  logic        bus_clock_output, ext_data_oe, chip_select_n;
  logic        read_strobe_n, write_strobe_n, read_not_write_line;
  logic        external_ready_in, cs_prev;
  logic [18:0] ext_addr, addr_prev;
  logic [15:0] ext_data_out, ext_data_in;
  logic [7:0]  hold;
  int          n_errors, n_checks, cyc, cl, sl, last_cl, last_sl;
  int          c, s, s1, s2, base;

  ebw_ctrl uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .bus_clock_output(bus_clock_output),
    .ext_addr(ext_addr), .ext_data_out(ext_data_out),
    .ext_data_oe(ext_data_oe), .ext_data_in(ext_data_in),
    .chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n),
    .read_not_write_line(read_not_write_line),
    .external_ready_in(external_ready_in));

  ebw_mem_model mem (.hclk(hclk), .hresetn(hresetn),
    .chip_select_n(chip_select_n), .write_strobe_n(write_strobe_n),
    .read_not_write_line(read_not_write_line),
    .ext_data_out(ext_data_out), .ext_data_oe(ext_data_oe),
    .ext_data_in(ext_data_in), .external_ready_in(external_ready_in),
    .hold_low(hold));

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report

  task automatic rdy;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
  endtask : rdy

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= {24'h0, a};
    rdy();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    rdy();
    q = hrdata;
    chk("hresp", hresp, 32'h0);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask : rd

  // Lead 1, active 7, trail 2 for both directions
  function automatic logic [31:0] tcfg(input logic en, input logic sty,
                                       input logic dbl);
    tcfg = (32'h1 << ebw_pkg::RD_LEAD_LSB) | (32'h7 << ebw_pkg::RD_ACT_LSB)
         | (32'h2 << ebw_pkg::RD_TRAIL_LSB) | (32'h1 << ebw_pkg::WR_LEAD_LSB)
         | (32'h7 << ebw_pkg::WR_ACT_LSB) | (32'h2 << ebw_pkg::WR_TRAIL_LSB)
         | ({31'h0, en} << ebw_pkg::READY_EN_BIT)
         | ({31'h0, dbl} << ebw_pkg::DOUBLING_BIT)
         | ({31'h0, sty} << ebw_pkg::STYLE_BIT);
  endfunction : tcfg

  // Starts one access and returns select and strobe lengths
  task automatic run(input logic w, input logic [7:0] h,
                     output int cn, output int sn);
    logic [31:0] st;
    hold <= h;
    wr(ebw_pkg::OFS_CTRL, {30'h0, w, 1'b1});
    for (int i = 0; i < 100; i++) begin
      rd(ebw_pkg::OFS_STATUS, st);
      if (st[ebw_pkg::STAT_BUSY_BIT] === 1'b0) break;
    end
    cn = last_cl;
    sn = last_sl;
  endtask : run

  // Pin monitor: measures each access and watches idle cycles
  always @(posedge hclk) begin
    if (hresetn === 1'b1) begin
      if (chip_select_n === 1'b0) begin
        if (cs_prev === 1'b1) chk("clk_at_start", bus_clock_output, 1);
        cl = cl + 1;
        if (!read_strobe_n || !write_strobe_n) sl = sl + 1;
      end else begin
        chk("idle_lines", {read_strobe_n, write_strobe_n,
            read_not_write_line}, 3'b111);
        if (cs_prev === 1'b1) chk("addr_hold", ext_addr, addr_prev);
        if (cs_prev === 1'b0) begin
          last_cl = cl;
          last_sl = sl;
        end
        cl = 0;
        sl = 0;
      end
      cs_prev = chip_select_n;
      addr_prev = ext_addr;
    end
  end

  always @(posedge hclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      $display("Error timeout expected finish seen hang");
      final_report();
    end
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    hold = 8'h00;
    cs_prev = 1'b1;
    addr_prev = 19'h0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(ebw_pkg::OFS_TIMING, v);
    chk("timing_rst", v, {15'h0, ebw_pkg::TIMING_RST});
    wr(8'h20, 32'hffffffff);
    rd(8'h20, v);
    chk("unmapped", v, 32'h0);
    wr(ebw_pkg::OFS_ADDR, 32'h5a5a5);
    wr(ebw_pkg::OFS_WDATA, 32'hc3a5);
    wr(ebw_pkg::OFS_TIMING, tcfg(1'b0, 1'b0, 1'b0));
    run(1'b1, 8'd40, c, s);
    chk("wr_cs_len", c, 10);
    chk("wr_st_len", s, 7);
    run(1'b0, 8'd40, c, s);
    chk("rd_cs_len", c, 10);
    chk("rd_st_len", s, 7);
    rd(ebw_pkg::OFS_RDATA, v);
    chk("rdata", v, 32'hc3a5);
    chk("ext_addr", ext_addr, 19'h5a5a5);
    rd(ebw_pkg::OFS_STATUS, v);
    chk("status_done", v, 32'h2);
    wr(ebw_pkg::OFS_TIMING, tcfg(1'b0, 1'b0, 1'b1));
    run(1'b0, 8'd40, c, s);
    chk("dbl_cs_len", c, 20);
    chk("dbl_st_len", s, 14);
    for (int w = 0; w < 2; w++) begin
      for (int y = 0; y < 2; y++) begin
        wr(ebw_pkg::OFS_TIMING, tcfg(1'b1, y[0], 1'b0));
        run(w[0], 8'd0, c, s);
        chk("ready_high_len", s, 7);
        run(w[0], 8'd12, c, s1);
        chk("trail_after", c - s1, 3);
        run(w[0], 8'd13, c, s2);
        chk("resample_step", s2 - s1, 1);
        if (y == 0) base = s1;
        else chk("async_early", s1 - base, ebw_pkg::ASYNC_EARLY);
      end
    end
    final_report();
  end
endmodule : tb_top
`default_nettype wire
